// *** core/wdog_cfg.svh ***
// Constants for the operating watchdog: offsets, fields, reset values, counts
`ifndef WDOG_CFG_SVH
`define WDOG_CFG_SVH

// Register byte addresses (service location index is scaled by four)
`define SERVICE_INDEX      18'h0FFFF
`define ADDR_SERVICE       {`SERVICE_INDEX, 2'b00}
`define ADDR_CONFIG        20'h00000
`define ADDR_STATUS        20'h00004
`define ADDR_MASK          20'h00008
`define ADDR_STATE         20'h0000C
`define ADDR_WIDTH         20

// Config register fields
`define CFG_DISABLE_BIT    0
`define CFG_LONG_BIT       1
`define CFG_STOP_EN_BIT    2
`define CFG_RESET          3'h0

// Status / mask fields
`define ST_WDOG_RESET_BIT  0
`define ST_SERVICE_BIT     1
`define ST_WIDTH           2
`define ST_RESET           2'h0
`define MASK_RESET         2'h0

// Counter geometry and timeout compare points
`define PRESCALE_WIDTH     12
`define COUNT_WIDTH        6
`define COUNT_MAX          6'h3F
`define SHORT_TAP_MASK     12'h07F
`define LONG_TAP_MASK      12'hFFF
`define SHORT_LAST         12'h06F
`define LONG_LAST          12'hFEF
`define SERVICE_KEEP_MASK  12'h007
`define PRESCALE_ZERO      12'h000
`define COUNT_ZERO         6'h00

// Reset pin stretch and power-up delay, in crystal cycles
`define PIN_HOLD_CYCLES    6'h20
`define PIN_HOLD_WIDTH     6
`define POR_DELAY_CYCLES   13'h1000
`define POR_DELAY_WIDTH    13

`endif

// *** core/wdog_pkg.sv ***
// Types shared by the operating watchdog design files
package wdog_pkg;

    // Synchronous qualifiers from the mode and pin logic
    typedef struct packed {
        logic monitor_mode;
        logic break_active;
        logic irq_high_voltage_level;
        logic rst_high_voltage_level;
    } wdog_qual_t;

    // Core events from the processor
    typedef struct packed {
        logic stop_exec;
        logic stop_mode;
        logic wait_mode;
        logic internal_reset;
        logic reset_vector_fetch;
    } cpu_event_t;

    typedef struct packed {
        logic stop_enable;
        logic long_timeout_select;
        logic watchdog_disable_bit;
    } wdog_config_t;

    // Two states, one bit apart
    typedef enum logic [0:0] {
        PIN_IDLE = 1'b0,
        PIN_HOLD = 1'b1
    } pin_state_t;

    typedef struct packed {
        pin_state_t  state;
        logic [5:0]  count;
    } pin_regs_t;

    typedef struct packed {
        logic [12:0] count;
        logic        done;
        logic        clear;
    } por_regs_t;

    typedef struct packed {
        wdog_config_t config_reg;
        logic [1:0]   status;
        logic [1:0]   mask;
        logic [11:0]  prescaler;
        logic [5:0]   counter;
        logic [31:0]  prdata;
        logic         overflow;
    } wdog_regs_t;

endpackage

// *** core/reset_pin_stretch.sv ***
// Holds the open-drain reset pin low for a fixed number of crystal cycles
`timescale 1ns/1ns
`include "wdog_cfg.svh"
module reset_pin_stretch (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic trigger,
    output logic      pin_out,
    output logic      pin_oe_n,
    output logic      busy
);
    import wdog_pkg::*;

    pin_regs_t regs;
    pin_regs_t next_regs;

    // Retrigger during a hold is ignored; the pin is already low
    always_comb begin
        next_regs = regs;
        case (regs.state)
            PIN_IDLE: begin
                if (trigger) begin
                    next_regs.state = PIN_HOLD;
                    next_regs.count = `PIN_HOLD_CYCLES;
                end
            end
            PIN_HOLD: begin
                next_regs.count = regs.count - 6'h01;
                if (regs.count == 6'h01) begin
                    next_regs.state = PIN_IDLE;
                end
            end
            default: begin
                next_regs.state = PIN_IDLE;
                next_regs.count = `PIN_HOLD_CYCLES;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regs <= '{state: PIN_IDLE, count: 6'h00};
        end else begin
            regs <= next_regs;
        end
    end

    // Drive low only, enable low while driving
    assign busy     = (regs.state == PIN_HOLD);
    assign pin_out  = 1'b0;
    assign pin_oe_n = ~busy;
endmodule

// *** core/por_clear_delay.sv ***
// Counts crystal cycles after power-up and pulses a prescaler clear once
`timescale 1ns/1ns
`include "wdog_cfg.svh"
module por_clear_delay (
    input  wire logic clk,
    input  wire logic rst_n,
    output logic      clear
);
    import wdog_pkg::*;

    por_regs_t regs;
    por_regs_t next_regs;

    // One pulse only; the counter parks once done
    always_comb begin
        next_regs       = regs;
        next_regs.clear = 1'b0;
        if (!regs.done) begin
            next_regs.count = regs.count + 13'h0001;
            if (regs.count == `POR_DELAY_CYCLES - 13'h0001) begin
                next_regs.done  = 1'b1;
                next_regs.clear = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regs <= '{count: 13'h0000, done: 1'b0, clear: 1'b0};
        end else begin
            regs <= next_regs;
        end
    end

    assign clear = regs.clear;
endmodule

// *** core/operating_watchdog_timer.sv ***
// Operating watchdog: prescaler, timeout counter, reset pin and APB registers
//
// Operation
// - Six-bit free-running counter fed by twelve-bit prescaler, both on crystal clock.
// - Unserviced, overflow raises reset after short or long count per select bit.
// - Reading the service location returns the reset vector low byte.
// - Overflow holds reset pin low 32 cycles and sets the cause bit.
// - Monitor mode with high voltage on interrupt or reset pin disables watchdog.
// - During break, high voltage on reset pin disables watchdog.
// - Stop instruction clears prescaler; stop mode freezes the watchdog clock.
// - Power-up logic clears prescaler after 4096 crystal cycles.
// - Internal reset clears prescaler and counter.
// - Reset vector fetch clears the prescaler.
// - Disable and long timeout follow the configuration register bits.
// - Watchdog never raises a processor interrupt; overflow resets and sets the cause bit seen on status_irq.
// - Counting continues during wait mode.
// - Stop only acts when the stop enable bit is set.
//
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`include "wdog_cfg.svh"
module operating_watchdog_timer (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic [31:0]               prdata,
    // Core side
    input  wire wdog_pkg::wdog_qual_t qual,
    input  wire wdog_pkg::cpu_event_t cpu_event,
    input  wire logic [7:0]           reset_vector_low,
    // Reset and status outputs
    output logic                      watchdog_reset,
    output logic                      reset_pin_out,
    output logic                      reset_pin_oe_n,
    output logic                      status_irq
);
    import wdog_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    typedef enum logic [2:0] {
        SEL_NONE    = 3'h0,
        SEL_CONFIG  = 3'h1,
        SEL_STATUS  = 3'h2,
        SEL_MASK    = 3'h3,
        SEL_STATE   = 3'h4,
        SEL_SERVICE = 3'h5
    } reg_sel_t;

    // Shared by the read capture and the write strobe
    function automatic reg_sel_t decode(input logic [31:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (addr[31:`ADDR_WIDTH] == '0) begin
            case (addr[`ADDR_WIDTH-1:0])
                `ADDR_CONFIG:  sel = SEL_CONFIG;
                `ADDR_STATUS:  sel = SEL_STATUS;
                `ADDR_MASK:    sel = SEL_MASK;
                `ADDR_STATE:   sel = SEL_STATE;
                `ADDR_SERVICE: sel = SEL_SERVICE;
                default:       sel = SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    wdog_regs_t   regs;
    wdog_regs_t   next_regs;
    reg_sel_t     sel;
    logic         setup_phase;
    logic         write_take;
    logic         service_write;
    logic         stop_active;
    logic         stop_clear;
    logic         disabled;
    logic         tap;
    logic         at_last;
    logic         por_clear;
    logic         pin_busy;
    logic [11:0]  tap_mask;
    logic [11:0]  last_value;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    por_clear_delay u_por (
        .clk   (clk),
        .rst_n (rst_n),
        .clear (por_clear)
    );

    reset_pin_stretch u_pin (
        .clk      (clk),
        .rst_n    (rst_n),
        .trigger  (regs.overflow),
        .pin_out  (reset_pin_out),
        .pin_oe_n (reset_pin_oe_n),
        .busy     (pin_busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus strobes and watchdog qualifiers

    // Zero wait states: read data is captured during setup
    assign sel           = decode(paddr);
    assign setup_phase   = psel & ~penable;
    assign pready        = 1'b1;
    assign pslverr       = psel & penable & (sel == SEL_NONE);
    assign write_take    = psel & penable & pwrite & (sel != SEL_NONE);
    assign service_write = write_take & (sel == SEL_SERVICE);

    // Stop has no effect unless software enabled it
    assign stop_active = regs.config_reg.stop_enable & cpu_event.stop_mode;
    assign stop_clear  = regs.config_reg.stop_enable & cpu_event.stop_exec;

    // Qualifiers are already synchronous; wait mode does not appear here
    assign disabled = regs.config_reg.watchdog_disable_bit
                    | (qual.monitor_mode
                       & (qual.irq_high_voltage_level | qual.rst_high_voltage_level))
                    | (qual.break_active & qual.rst_high_voltage_level);

    // Tap and compare point follow the timeout select
    assign tap_mask   = regs.config_reg.long_timeout_select ? `LONG_TAP_MASK
                                                            : `SHORT_TAP_MASK;
    assign last_value = regs.config_reg.long_timeout_select ? `LONG_LAST
                                                            : `SHORT_LAST;
    assign tap        = (regs.prescaler & tap_mask) == tap_mask;
    // Sixteen cycles short of the full span so the overflow edge lands exactly
    assign at_last    = (regs.counter == `COUNT_MAX)
                      & ((regs.prescaler & tap_mask) == last_value);

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_regs          = regs;
        next_regs.overflow = 1'b0;

        // Counting, frozen while the crystal clock is gated by stop
        if (!disabled && !stop_active) begin
            next_regs.prescaler = regs.prescaler + 12'h001;
            if (tap) begin
                next_regs.counter = regs.counter + 6'h01;
            end
            if (at_last) begin
                next_regs.overflow  = 1'b1;
                next_regs.prescaler = `PRESCALE_ZERO;
                next_regs.counter   = `COUNT_ZERO;
            end
        end

        // Service keeps the three lowest prescaler stages and beats a same-cycle overflow
        if (service_write) begin
            next_regs.prescaler = regs.prescaler & `SERVICE_KEEP_MASK;
            next_regs.counter   = `COUNT_ZERO;
            next_regs.overflow  = 1'b0;
        end

        // Prescaler clears
        if (stop_clear || por_clear || cpu_event.reset_vector_fetch) begin
            next_regs.prescaler = `PRESCALE_ZERO;
        end
        if (cpu_event.internal_reset) begin
            next_regs.prescaler = `PRESCALE_ZERO;
            next_regs.counter   = `COUNT_ZERO;
            next_regs.overflow  = 1'b0;
        end

        // Software registers
        if (write_take) begin
            case (sel)
                SEL_CONFIG: begin
                    next_regs.config_reg.watchdog_disable_bit = pwdata[`CFG_DISABLE_BIT];
                    next_regs.config_reg.long_timeout_select  = pwdata[`CFG_LONG_BIT];
                    next_regs.config_reg.stop_enable          = pwdata[`CFG_STOP_EN_BIT];
                end
                SEL_STATUS: begin
                    next_regs.status = regs.status & ~pwdata[`ST_WIDTH-1:0];
                end
                SEL_MASK: begin
                    next_regs.mask = pwdata[`ST_WIDTH-1:0];
                end
                default: begin
                end
            endcase
        end

        // Hardware sets win over a same-cycle clear
        if (regs.overflow) begin
            next_regs.status[`ST_WDOG_RESET_BIT] = 1'b1;
        end
        if (service_write) begin
            next_regs.status[`ST_SERVICE_BIT] = 1'b1;
        end

        // Read capture in setup; service reads the vector byte only
        if (setup_phase) begin
            case (sel)
                SEL_CONFIG:  next_regs.prdata = {29'h0, regs.config_reg.stop_enable,
                                                 regs.config_reg.long_timeout_select,
                                                 regs.config_reg.watchdog_disable_bit};
                SEL_STATUS:  next_regs.prdata = {30'h0, regs.status};
                SEL_MASK:    next_regs.prdata = {30'h0, regs.mask};
                SEL_STATE:   next_regs.prdata = {10'h000, pin_busy, disabled, 2'h0,
                                                 regs.counter, regs.prescaler};
                SEL_SERVICE: next_regs.prdata = {24'h0, reset_vector_low};
                default:     next_regs.prdata = 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regs <= '{config_reg: `CFG_RESET,
                      status:     `ST_RESET,
                      mask:       `MASK_RESET,
                      prescaler:  `PRESCALE_ZERO,
                      counter:    `COUNT_ZERO,
                      prdata:     32'h0,
                      overflow:   1'b0};
        end else begin
            regs <= next_regs;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Overflow pulse is the only action toward the core
    assign watchdog_reset = regs.overflow;
    assign prdata         = regs.prdata;
    // System status line, not a processor interrupt request
    assign status_irq     = |(regs.status & regs.mask);
endmodule

// *** verif/wdog_checker_properties.sv ***
// Port-level checker for the operating watchdog timer
`timescale 1ns/1ns
`include "wdog_cfg.svh"
module wdog_checker
    import wdog_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire wdog_qual_t  qual,
    input wire cpu_event_t  cpu_event,
    input wire logic [7:0]  reset_vector_low,
    input wire logic        watchdog_reset,
    input wire logic        reset_pin_out,
    input wire logic        reset_pin_oe_n,
    input wire logic        status_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    // Length of the current low stretch on the reset pin
    logic [5:0] low_run;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_run <= 6'h00;
        end else if (reset_pin_oe_n) begin
            low_run <= 6'h00;
        end else begin
            low_run <= low_run + 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Service access and the quiet period that must follow a restart
    sequence s_svc;
        psel && penable && pwrite && paddr == {12'h000, `ADDR_SERVICE};
    endsequence
    sequence s_quiet;
        !watchdog_reset [*8];
    endsequence

    property p_svc_quiet; s_svc |=> s_quiet; endproperty
    a_svc_quiet: assert property (p_svc_quiet) else $error("reset soon after service");
    property p_rst_quiet; cpu_event.internal_reset |=> s_quiet; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("reset soon after clear");
    property p_pulse; watchdog_reset |=> !watchdog_reset; endproperty
    a_pulse: assert property (p_pulse) else $error("overflow pulse too long");
    property p_pin_start; watchdog_reset |-> ##[1:2] !reset_pin_oe_n; endproperty
    a_pin_start: assert property (p_pin_start) else $error("pin not pulled low");
    property p_pin_len; $rose(reset_pin_oe_n) |-> low_run == 6'h20; endproperty
    a_pin_len: assert property (p_pin_len) else $error("pin low length wrong");
    property p_pin_low; !reset_pin_oe_n |-> !reset_pin_out; endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin driven high");
    property p_mon_off;
        (qual.monitor_mode && (qual.irq_high_voltage_level || qual.rst_high_voltage_level))[*2]
            |-> !watchdog_reset;
    endproperty
    a_mon_off: assert property (p_mon_off) else $error("reset in monitor mode");
    property p_brk_off;
        (qual.break_active && qual.rst_high_voltage_level)[*2] |-> !watchdog_reset;
    endproperty
    a_brk_off: assert property (p_brk_off) else $error("reset during break");
    property p_svc_read;
        psel && penable && !pwrite && paddr == {12'h000, `ADDR_SERVICE}
            |-> prdata == {24'h000000, $past(reset_vector_low)};
    endproperty
    a_svc_read: assert property (p_svc_read) else $error("service read wrong");
    property p_unmapped; psel && penable && paddr[31:20] != 12'h000 |-> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
endmodule
bind operating_watchdog_timer wdog_checker wdog_checker_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .qual(qual), .cpu_event(cpu_event), .reset_vector_low(reset_vector_low),
    .watchdog_reset(watchdog_reset), .reset_pin_out(reset_pin_out),
    .reset_pin_oe_n(reset_pin_oe_n), .status_irq(status_irq));

// *** verif/cpu_software_model.sv ***
// Software side model: APB master that reads, writes and services
`timescale 1ns/1ns
`include "wdog_cfg.svh"
module cpu_software_model (
    input  wire logic        clk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [31:0]      paddr,
    output logic [31:0]      pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // One transfer, request held until pready is seen high at an edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e, output logic hung);
        int i;
        i = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && i < 64) begin
            @(posedge clk);
            i++;
        end
        r = prdata;
        e = pslverr;
        hung = (i >= 64);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Main-loop service; data is ignored by the device
    task automatic service(input logic [31:0] d, output logic hung);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, {12'h000, `ADDR_SERVICE}, d, r, e, hung);
    endtask
endmodule

// *** verif/test_operating_watchdog_timer.sv ***
// Self-checking bench for the operating watchdog timer
`timescale 1ns/1ns
`include "wdog_cfg.svh"
`define CHK(a, b, m) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t %s", $time, m); end end
module test_operating_watchdog_timer;
    import wdog_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, e, hung;
    logic [31:0] paddr, pwdata, prdata, r, s1, s2;
    wdog_qual_t  qual = '0;
    cpu_event_t  cpu_event = '0;
    logic [7:0]  vec = 8'h00;
    logic [11:0] hi = 12'h000;
    logic        wd, pin_out, pin_oe_n, irq;
    int          n_mismatch = 0, checked = 0, n, k;

    always #5 clk = ~clk;

    operating_watchdog_timer operating_watchdog_timer_i (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .qual(qual), .cpu_event(cpu_event), .reset_vector_low(vec), .watchdog_reset(wd),
        .reset_pin_out(pin_out), .reset_pin_oe_n(pin_oe_n), .status_irq(irq));
    cpu_software_model cpu_software_model_i (
        .clk(clk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (n_mismatch == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Register access; a hung bus ends the run
    task automatic acc(input logic w, input logic [19:0] a, input logic [31:0] d);
        if (w && a == `ADDR_SERVICE) begin
            cpu_software_model_i.service(d, hung);
        end else begin
            cpu_software_model_i.xfer(w, {hi, a}, d, r, e, hung);
        end
        if (hung) begin
            n_mismatch++;
            summarize();
        end
    endtask

    // Cycles from a cleared counter to the overflow pulse, less the kept stages
    function automatic int expect_timeout(input logic long_sel, input int kept);
        return (long_sel ? (1 << 18) : (1 << 13)) - (1 << 4) - kept;
    endfunction

    // One-cycle core event on a field index
    task automatic pulse(input int b);
        @(posedge clk);
        cpu_event[b] <= 1'b1;
        @(posedge clk);
        cpu_event[b] <= 1'b0;
    endtask

    // Edges until the overflow pulse, bounded
    task automatic wait_wd(input int lim, input bit must);
        n = 0;
        while (n < lim) begin
            @(posedge clk);
            n++;
            #1;
            if (wd === 1'b1) break;
        end
        // A required pulse (must set) that never comes ends the run
        if (must && wd !== 1'b1) begin
            n_mismatch++;
            summarize();
        end
    endtask

    // Two state snapshots 303 cycles apart
    task automatic freeze();
        acc(1'b0, `ADDR_STATE, 32'h0);
        s1 = r;
        repeat (300) @(posedge clk);
        acc(1'b0, `ADDR_STATE, 32'h0);
        s2 = r;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(2048));
        vec <= 8'($urandom());
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        acc(1'b0, `ADDR_CONFIG, 32'h0);
        `CHK(r, 32'h0, "config reset")
        acc(1'b0, 20'h00010, 32'h0);
        `CHK({e, r}, 33'h100000000, "unmapped")
        hi = 12'h001;
        acc(1'b0, `ADDR_CONFIG, 32'h0);
        hi = 12'h000;
        `CHK({e, r}, 33'h100000000, "upper address")
        acc(1'b0, `ADDR_SERVICE, 32'h0);
        `CHK(r, {24'h000000, vec}, "service read")
        acc(1'b1, `ADDR_SERVICE, $urandom());
        acc(1'b1, `ADDR_CONFIG, 32'h1);
        freeze();
        `CHK(s1[17:0], s2[17:0], "disable bit")
        acc(1'b1, `ADDR_CONFIG, 32'h0);
        // Last case is break with irq high voltage only: must keep running
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            qual <= (k == 0) ? 4'hA : (k == 1) ? 4'h9 : (k == 2) ? 4'h5 : 4'h6;
            freeze();
            `CHK(s1[17:0] === s2[17:0], k < 3, "qualified disable")
            `CHK(s2[20], k < 3, "disabled flag")
        end
        @(posedge clk);
        qual <= '0;
        acc(1'b1, `ADDR_CONFIG, 32'h4);
        @(posedge clk);
        cpu_event.stop_mode <= 1'b1;
        pulse(4);
        freeze();
        `CHK(s2[11:0], 12'h000, "stop clear")
        `CHK(s1[17:0], s2[17:0], "stop freeze")
        acc(1'b1, `ADDR_CONFIG, 32'h0);
        pulse(4);
        freeze();
        `CHK(s1[17:0] === s2[17:0], 1'b0, "stop ignored")
        @(posedge clk);
        cpu_event.stop_mode <= 1'b0;
        pulse(0);
        acc(1'b0, `ADDR_STATE, 32'h0);
        `CHK(r[11:3], 9'h000, "vector fetch")
        // Sit out the power-up clear so it cannot skew the timing below
        acc(1'b1, `ADDR_CONFIG, 32'h1);
        repeat (3000) @(posedge clk);
        acc(1'b0, `ADDR_STATE, 32'h0);
        `CHK(r[11:0], 12'h000, "power-up clear")
        acc(1'b1, `ADDR_CONFIG, 32'h0);
        @(posedge clk);
        cpu_event.wait_mode <= 1'b1;
        pulse(1);
        wait_wd(9000, 1'b1);
        `CHK(n, expect_timeout(1'b0, 0), "short timeout")
        `CHK(irq, 1'b0, "no interrupt")
        k = 0;
        repeat (40) begin
            @(posedge clk);
            #1;
            if (pin_oe_n === 1'b0) k++;
        end
        `CHK(k, 32, "pin hold")
        acc(1'b0, `ADDR_STATUS, 32'h0);
        `CHK(r[0], 1'b1, "cause bit")
        acc(1'b1, `ADDR_MASK, 32'h1);
        #1;
        `CHK(irq, 1'b1, "irq raised")
        acc(1'b1, `ADDR_STATUS, 32'h3);
        #1;
        `CHK(irq, 1'b0, "irq cleared")
        acc(1'b1, `ADDR_MASK, 32'h0);
        pulse(1);
        k = $urandom_range(3000, 100);
        repeat (k) @(posedge clk);
        acc(1'b1, `ADDR_SERVICE, $urandom());
        wait_wd(9000, 1'b1);
        // Setup and access add two counts before the low stages are kept
        `CHK(n, expect_timeout(1'b0, (k + 2) % 8), "service restart")
        acc(1'b1, `ADDR_CONFIG, 32'h2);
        pulse(1);
        wait_wd(9000, 1'b0);
        `CHK(n, 9000, "long select")
        acc(1'b0, `ADDR_STATE, 32'h0);
        `CHK(r[17:12], 6'h02, "long count")
        summarize();
    end
endmodule
